// >>> ahrp_defines.svh
// Constants of the asynchronous host register port
// Function
// - Mode pins 00 strobe pair, 01 direction strobe
// - Read, write and data strobes ignored unless chip select low
// - Address strobe high opens address path
// - Address strobe fall latches the address
// - Strobe tied high uses live address
// - Pair read strobe low drives register data
// - Ready low once read data valid
// - Pair write strobe low takes data in
// - Write acknowledge on the edge that stores the byte; writes to 0xFE and 0xFF acknowledged unstored
// - Direction high during data strobe reads
// - Direction low during data strobe writes
// - Data strobe low completes access, then ack
// - Eight channels of sixteen registers each
// - Globals at 0x80 to 0x8E and 0xC0
// - Remaining 0x8F to 0xFD are test registers
// - Identity at 0xFE, revision at 0xFF
// - Acknowledge low until access finishes
`ifndef AHRP_DEFINES_SVH
`define AHRP_DEFINES_SVH

//----------------------------------------
// Bus style selection
//----------------------------------------
`define AHRP_MODE_STROBE_PAIR 2'h0
`define AHRP_MODE_DIR_STROBE  2'h1

//----------------------------------------
// Address map
//----------------------------------------
`define AHRP_CHAN_LAST        8'h7F
`define AHRP_GLOBAL_FIRST     8'h80
`define AHRP_GLOBAL_LAST      8'h8E
`define AHRP_GLOBAL_EXTRA     8'hC0
`define AHRP_TEST_FIRST       8'h8F
`define AHRP_TEST_LAST        8'hFD
`define AHRP_ID_ADDR          8'hFE
`define AHRP_REV_ADDR         8'hFF
`define AHRP_REG_RESET        8'h00

//----------------------------------------
// Timing
//----------------------------------------
`define AHRP_CLK_PERIOD_NS    20
`define AHRP_ACK_MAX_NS       90
`define AHRP_ACK_MAX_CYC      (`AHRP_ACK_MAX_NS / `AHRP_CLK_PERIOD_NS)

`endif

// >>> ahrp_pkg.sv
// Types of the asynchronous host register port
`include "ahrp_defines.svh"

package ahrp_pkg;

   //----------------------------------------
   // Address regions
   //----------------------------------------
   typedef enum logic [2:0] {
      AHRP_REG_CHANNEL  = 3'b000,
      AHRP_REG_GLOBAL   = 3'b001,
      AHRP_REG_TEST     = 3'b010,
      AHRP_REG_IDENTITY = 3'b011,
      AHRP_REG_REVISION = 3'b100
   } ahrp_region_t;

   //----------------------------------------
   // Port sequencer states
   //----------------------------------------
   typedef enum logic [1:0] {
      AHRP_ST_IDLE = 2'b00,
      AHRP_ST_ACK  = 2'b01
   } ahrp_state_t;

   //----------------------------------------
   // Register update carried to the core
   //----------------------------------------
   typedef struct packed {
      logic         valid;
      ahrp_region_t region;
      logic [2:0]   channel;
      logic [3:0]   offset;
      logic [7:0]   addr;
      logic [7:0]   data;
   } ahrp_update_t;

endpackage : ahrp_pkg

// >>> ahrp_port.sv
// Asynchronous 8-bit host register port with address map
`timescale 1ns/10ps
`include "ahrp_defines.svh"

module ahrp_port
   import ahrp_pkg::*;
#(
   parameter logic [7:0] DEVICE_IDENTITY = 8'h5A,  // Arbitrary value
   parameter logic [7:0] DEVICE_REVISION = 8'h01   // Arbitrary value
) (
   input  wire logic         mclk,
   input  wire logic         rst_b,
   input  wire logic         clk_en,
   input  wire logic [1:0]   host_port_mode_pins,
   input  wire logic [7:0]   addr,
   input  wire logic         cs_b,
   input  wire logic         address_valid_strobe,
   input  wire logic         read_or_data_strobe_b,
   input  wire logic         write_or_direction,
   input  wire logic [7:0]   data_in,
   output logic [7:0]        data_out,
   output logic              data_oe,
   output logic              transfer_ack_b,
   output ahrp_update_t      reg_update
);

   localparam int ACK_CYC = `AHRP_ACK_MAX_CYC;

   //----------------------------------------
   // Declarations
   //----------------------------------------
   logic [3:0]   sync_1;
   logic [3:0]   sync_2;
   logic         strobe_prev;
   logic         cs_s;
   logic         strobe_s;
   logic         data_strobe_s;
   logic         rw_s;
   logic [7:0]   addr_q;
   logic         rd_req;
   logic         wr_req;
   logic [7:0]   rd_value;
   ahrp_region_t region;
   ahrp_state_t  state;
   ahrp_state_t  next_state;
   logic [7:0]   reg_mem [0:253];

   //----------------------------------------
   // Input synchronisers
   //----------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         sync_1 <= 4'hF;
         sync_2 <= 4'hF;
      end else if (clk_en) begin
         sync_1 <= {cs_b, address_valid_strobe, read_or_data_strobe_b,
                    write_or_direction};
         sync_2 <= sync_1;
      end
   end

   assign cs_s          = sync_2[3];
   assign strobe_s      = sync_2[2];
   assign data_strobe_s = sync_2[1];
   assign rw_s          = sync_2[0];

   //----------------------------------------
   // Address latch
   //----------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         strobe_prev <= 1'b1;
         addr_q      <= 8'h00;
      end else if (clk_en) begin
         strobe_prev <= strobe_s;
         if (strobe_s) begin
            addr_q <= addr;
         end else if (strobe_prev) begin
            addr_q <= addr_q;
         end
      end
   end

   //----------------------------------------
   // Access decode
   //----------------------------------------
   always_comb begin
      rd_req = 1'b0;
      wr_req = 1'b0;
      case (host_port_mode_pins)
         `AHRP_MODE_STROBE_PAIR: begin
            rd_req = !cs_s && !data_strobe_s;
            wr_req = !cs_s && !rw_s && data_strobe_s;
         end
         `AHRP_MODE_DIR_STROBE: begin
            rd_req = !cs_s && !data_strobe_s && rw_s;
            wr_req = !cs_s && !data_strobe_s && !rw_s;
         end
         default: begin
            rd_req = 1'b0;
            wr_req = 1'b0;
         end
      endcase
   end

   //----------------------------------------
   // Address map decode
   //----------------------------------------
   always_comb begin
      region = AHRP_REG_TEST;
      if (addr_q <= `AHRP_CHAN_LAST) begin
         region = AHRP_REG_CHANNEL;
      end else if ((addr_q >= `AHRP_GLOBAL_FIRST && addr_q <= `AHRP_GLOBAL_LAST) ||
                   addr_q == `AHRP_GLOBAL_EXTRA) begin
         region = AHRP_REG_GLOBAL;
      end else if (addr_q == `AHRP_ID_ADDR) begin
         region = AHRP_REG_IDENTITY;
      end else if (addr_q == `AHRP_REV_ADDR) begin
         region = AHRP_REG_REVISION;
      end
   end

   always_comb begin
      case (region)
         AHRP_REG_IDENTITY: rd_value = DEVICE_IDENTITY;
         AHRP_REG_REVISION: rd_value = DEVICE_REVISION;
         default:           rd_value = reg_mem[addr_q];
      endcase
   end

   //----------------------------------------
   // Sequencer
   //----------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         AHRP_ST_IDLE: begin
            if (rd_req || wr_req) begin
               next_state = AHRP_ST_ACK;
            end
         end
         AHRP_ST_ACK: begin
            if (!rd_req && !wr_req) begin
               next_state = AHRP_ST_IDLE;
            end
         end
         default: next_state = AHRP_ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         state <= AHRP_ST_IDLE;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   //----------------------------------------
   // Handshake outputs
   //----------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         transfer_ack_b <= 1'b1;
         data_oe        <= 1'b0;
         data_out       <= 8'h00;
      end else if (clk_en) begin
         if (state == AHRP_ST_IDLE && (rd_req || wr_req)) begin
            transfer_ack_b <= 1'b0;
            data_oe        <= rd_req;
            if (rd_req) begin
               data_out <= rd_value;
            end
         end else if (state == AHRP_ST_ACK && !rd_req && !wr_req) begin
            transfer_ack_b <= 1'b1;
            data_oe        <= 1'b0;
         end
      end
   end

   //----------------------------------------
   // Register storage
   //----------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         for (int i = 0; i < 254; i++) begin
            reg_mem[i] <= `AHRP_REG_RESET;
         end
      end else if (clk_en) begin
         if (state == AHRP_ST_IDLE && wr_req && addr_q <= `AHRP_TEST_LAST) begin
            reg_mem[addr_q] <= data_in;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         reg_update <= '0;
      end else if (clk_en) begin
         reg_update.valid <= state == AHRP_ST_IDLE && wr_req &&
                             addr_q <= `AHRP_TEST_LAST;
         reg_update.region  <= region;
         reg_update.channel <= addr_q[6:4];
         reg_update.offset  <= addr_q[3:0];
         reg_update.addr    <= addr_q;
         reg_update.data    <= data_in;
      end
   end

   //----------------------------------------
   // Assertions
   //----------------------------------------
   default clocking ahrp_cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b || !clk_en);

   property p_mode_ignore;
      (state == AHRP_ST_IDLE && host_port_mode_pins[1]) |=> transfer_ack_b;
   endproperty
   a_mode_ignore: assert property (p_mode_ignore)
      else $error("Access taken in unsupported mode");

   property p_cs_gate;
      (state == AHRP_ST_IDLE && cs_s) |=> transfer_ack_b && !data_oe;
   endproperty
   a_cs_gate: assert property (p_cs_gate)
      else $error("Access taken with chip select high");

   property p_addr_hold;
      (!strobe_s && !strobe_prev) |=> $stable(addr_q);
   endproperty
   a_addr_hold: assert property (p_addr_hold)
      else $error("Latched address moved while strobe low");

   property p_addr_live;
      strobe_s [*2] |=> addr_q == $past(addr);
   endproperty
   a_addr_live: assert property (p_addr_live)
      else $error("Address path not following live bus");

   property p_read_data;
      (state == AHRP_ST_IDLE && rd_req) |=>
         !transfer_ack_b && data_oe && data_out == $past(rd_value);
   endproperty
   a_read_data: assert property (p_read_data)
      else $error("Read data not presented with ready");

   property p_ack_time;
      (state == AHRP_ST_IDLE && (rd_req || wr_req)) |-> ##[1:ACK_CYC] !transfer_ack_b;
   endproperty
   a_ack_time: assert property (p_ack_time)
      else $error("Acknowledge late");

   property p_write_no_drive;
      (state == AHRP_ST_IDLE && wr_req) |=> !data_oe [*1] ##0 !transfer_ack_b;
   endproperty
   a_write_no_drive: assert property (p_write_no_drive)
      else $error("Data bus driven during write");

   property p_write_stored;
      (state == AHRP_ST_IDLE && wr_req && addr_q <= `AHRP_TEST_LAST) |=>
         reg_mem[$past(addr_q)] == $past(data_in) && !transfer_ack_b;
   endproperty
   a_write_stored: assert property (p_write_stored)
      else $error("Acknowledge without stored byte");

   property p_ack_hold;
      (!transfer_ack_b && (rd_req || wr_req)) |=> !transfer_ack_b;
   endproperty
   a_ack_hold: assert property (p_ack_hold)
      else $error("Acknowledge dropped during access");

   property p_ack_release;
      (state == AHRP_ST_ACK && !rd_req && !wr_req) |=> transfer_ack_b && !data_oe;
   endproperty
   a_ack_release: assert property (p_ack_release)
      else $error("Acknowledge not released after strobe");

   property p_one_update;
      reg_update.valid |=> !reg_update.valid;
   endproperty
   a_one_update: assert property (p_one_update)
      else $error("Several updates from one strobe");

   property p_identity;
      (state == AHRP_ST_IDLE && rd_req && addr_q == `AHRP_ID_ADDR) |=>
         data_out == DEVICE_IDENTITY;
   endproperty
   a_identity: assert property (p_identity)
      else $error("Wrong identity value");

   property p_channel;
      (reg_update.valid && reg_update.region == AHRP_REG_CHANNEL) |->
         reg_update.addr == {1'b0, reg_update.channel, reg_update.offset};
   endproperty
   a_channel: assert property (p_channel)
      else $error("Channel decode mismatch");

   property p_global;
      (reg_update.valid && reg_update.addr == `AHRP_GLOBAL_EXTRA) |->
         reg_update.region == AHRP_REG_GLOBAL;
   endproperty
   a_global: assert property (p_global)
      else $error("Global register decoded wrongly");

   property p_test_region;
      (reg_update.valid && reg_update.addr >= `AHRP_TEST_FIRST &&
       reg_update.addr != `AHRP_GLOBAL_EXTRA) |-> reg_update.region == AHRP_REG_TEST;
   endproperty
   a_test_region: assert property (p_test_region)
      else $error("Test register decoded wrongly");

   property p_revision;
      (state == AHRP_ST_IDLE && rd_req && addr_q == `AHRP_REV_ADDR) |=>
         data_out == DEVICE_REVISION;
   endproperty
   a_revision: assert property (p_revision)
      else $error("Wrong revision value");

   property p_ro_no_store;
      (state == AHRP_ST_IDLE && wr_req && addr_q > `AHRP_TEST_LAST) |=>
         !reg_update.valid && !transfer_ack_b;
   endproperty
   a_ro_no_store: assert property (p_ro_no_store)
      else $error("Identity write stored");

   property p_write_data;
      reg_update.valid |-> reg_update.data == $past(data_in);
   endproperty
   a_write_data: assert property (p_write_data)
      else $error("Stored byte differs from data bus");

   property p_idle_quiet;
      state == AHRP_ST_IDLE |-> transfer_ack_b && !data_oe;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("Acknowledge or drive while idle");

   c_read_pair: cover property (
      host_port_mode_pins == `AHRP_MODE_STROBE_PAIR && state == AHRP_ST_IDLE && rd_req);
   c_write_dir: cover property (
      host_port_mode_pins == `AHRP_MODE_DIR_STROBE && state == AHRP_ST_IDLE && wr_req);
   c_id_read: cover property (
      state == AHRP_ST_IDLE && rd_req && addr_q == `AHRP_ID_ADDR);
   c_test_write: cover property (
      reg_update.valid && reg_update.region == AHRP_REG_TEST);
   c_read_dir: cover property (
      host_port_mode_pins == `AHRP_MODE_DIR_STROBE && state == AHRP_ST_IDLE && rd_req);

endmodule : ahrp_port

// >>> ahrp_host.sv
// Host processor model driving the register port
`timescale 1ns/10ps
module ahrp_host
   import ahrp_pkg::*;
(
   input  wire logic         mclk,
   input  wire ahrp_update_t reg_update,
   input  wire logic         transfer_ack_b,
   input  wire logic [7:0]   data_out,
   input  wire logic         data_oe,
   output logic [7:0]        addr,
   output logic              cs_b,
   output logic              address_valid_strobe,
   output logic              read_or_data_strobe_b,
   output logic              write_or_direction,
   output logic [7:0]        data_in
);
   ahrp_update_t upd;
   logic         oe_at_ack;
   initial begin
      addr = 8'h00;
      cs_b = 1'b1;
      address_valid_strobe = 1'b1;
      read_or_data_strobe_b = 1'b1;
      write_or_direction = 1'b1;
      data_in = 8'h00;
   end
   //----------------------------------------
   // One bus cycle, any style
   //----------------------------------------
   task automatic cycle(input logic m1, rd, sel, fall, input logic [7:0] a, d,
                        output logic [7:0] q, output logic ok);
      int i;
      ok = 1'b0;
      q = 8'h00;
      upd = '0;
      oe_at_ack = 1'b0;
      @(posedge mclk);
      addr <= a;
      cs_b <= ~sel;
      address_valid_strobe <= 1'b1;
      @(posedge mclk);
      address_valid_strobe <= ~fall;
      @(posedge mclk);
      data_in <= rd ? ~d : d;
      if (m1) write_or_direction <= rd;
      @(posedge mclk);
      if (m1 | rd) read_or_data_strobe_b <= 1'b0;
      else write_or_direction <= 1'b0;
      for (i = 0; i < 8 && !ok; i++) begin
         @(posedge mclk);
         #1;
         ok = (transfer_ack_b === 1'b0);
         if (reg_update.valid === 1'b1) upd = reg_update;
      end
      q = data_out;
      oe_at_ack = data_oe;
      @(posedge mclk);
      read_or_data_strobe_b <= 1'b1;
      write_or_direction <= 1'b1;
      cs_b <= 1'b1;
      address_valid_strobe <= 1'b1;
      data_in <= ~data_in;
      if (fall) addr <= ~a;
      for (i = 0; i < 8; i++) begin
         #1;
         if (reg_update.valid === 1'b1) upd = reg_update;
         @(posedge mclk);
      end
      #1;
      if (transfer_ack_b !== 1'b1) ok = 1'b0;
   endtask : cycle
endmodule : ahrp_host

// >>> tb_top.sv
// Self-checking bench of the host register port
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((e) !== (g)) begin n_fail++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top;
   import ahrp_pkg::*;
   localparam logic [7:0] ID  = 8'hC3;  // Arbitrary value
   localparam logic [7:0] REV = 8'h2E;  // Arbitrary value
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic [1:0] mode = 2'h0;
   logic ce = 1'b1;
   logic [7:0] addr, data_in, data_out, q;
   logic cs_b, avs, rds_b, wod, data_oe, ack_b, ok;
   ahrp_update_t upd;
   int n_fail = 0;
   int checks_done = 0;
   always #10 mclk = ~mclk;
   ahrp_port #(.DEVICE_IDENTITY(ID), .DEVICE_REVISION(REV)) DUT (
      .mclk(mclk), .rst_b(rst_b), .clk_en(ce), .host_port_mode_pins(mode),
      .addr(addr), .cs_b(cs_b), .address_valid_strobe(avs),
      .read_or_data_strobe_b(rds_b), .write_or_direction(wod), .data_in(data_in),
      .data_out(data_out), .data_oe(data_oe), .transfer_ack_b(ack_b),
      .reg_update(upd));
   ahrp_host H (
      .mclk(mclk), .reg_update(upd), .transfer_ack_b(ack_b), .data_out(data_out),
      .data_oe(data_oe),
      .addr(addr), .cs_b(cs_b), .address_valid_strobe(avs),
      .read_or_data_strobe_b(rds_b), .write_or_direction(wod), .data_in(data_in));
   //----------------------------------------
   // Scenarios
   //----------------------------------------
   task automatic t_map;
      logic [7:0] at [7] = '{8'h00, 8'h7F, 8'h80, 8'h8E, 8'hC0, 8'h8F, 8'hFD};
      ahrp_region_t rt [7] = '{AHRP_REG_CHANNEL, AHRP_REG_CHANNEL, AHRP_REG_GLOBAL,
         AHRP_REG_GLOBAL, AHRP_REG_GLOBAL, AHRP_REG_TEST, AHRP_REG_TEST};
      for (int i = 0; i < 7; i++) begin
         H.cycle(1'b0, 1'b0, 1'b1, 1'b1, at[i], at[i] ^ 8'hA5, q, ok);
         `CHK("wr_ack", 1'b1, ok)
         `CHK("wr_oe", 1'b0, H.oe_at_ack)
         `CHK("region", rt[i], H.upd.region)
         `CHK("upd_addr", at[i], H.upd.addr)
         `CHK("upd_data", at[i] ^ 8'hA5, H.upd.data)
         if (i < 2) `CHK("chan", at[i][6:4], H.upd.channel)
         if (i < 2) `CHK("offs", at[i][3:0], H.upd.offset)
      end
      for (int i = 0; i < 7; i++) begin
         H.cycle(1'b0, 1'b1, 1'b1, 1'b1, at[i], 8'h00, q, ok);
         `CHK("rd_ack", 1'b1, ok)
         `CHK("rd_oe", 1'b1, H.oe_at_ack)
         `CHK("rd_data", at[i] ^ 8'hA5, q)
      end
   endtask : t_map
   task automatic t_id;
      H.cycle(1'b0, 1'b1, 1'b1, 1'b1, 8'hFE, 8'h00, q, ok);
      `CHK("ident", ID, q)
      H.cycle(1'b0, 1'b1, 1'b1, 1'b1, 8'hFF, 8'h00, q, ok);
      `CHK("revision", REV, q)
      H.cycle(1'b0, 1'b0, 1'b1, 1'b1, 8'hFE, 8'h33, q, ok);
      `CHK("ro_ack", 1'b1, ok)
      `CHK("ro_upd", 1'b0, H.upd.valid)
      H.cycle(1'b0, 1'b1, 1'b1, 1'b1, 8'hFE, 8'h00, q, ok);
      `CHK("ident_kept", ID, q)
   endtask : t_id
   task automatic t_dir;
      @(posedge mclk);
      mode <= 2'h1;
      H.cycle(1'b1, 1'b0, 1'b1, 1'b1, 8'h35, 8'h6C, q, ok);
      `CHK("m1_wr_ack", 1'b1, ok)
      `CHK("m1_upd", 8'h6C, H.upd.data)
      H.cycle(1'b1, 1'b1, 1'b1, 1'b1, 8'h35, 8'h00, q, ok);
      `CHK("m1_rd", 8'h6C, q)
      H.cycle(1'b1, 1'b1, 1'b1, 1'b1, 8'hFF, 8'h00, q, ok);
      `CHK("m1_rev", REV, q)
      @(posedge mclk);
      mode <= 2'h0;
   endtask : t_dir
   task automatic t_cs;
      H.cycle(1'b0, 1'b0, 1'b0, 1'b1, 8'h10, 8'hEE, q, ok);
      `CHK("cs_high_ack", 1'b0, ok)
      H.cycle(1'b0, 1'b1, 1'b1, 1'b1, 8'h10, 8'h00, q, ok);
      `CHK("cs_high_kept", 8'h00, q)
   endtask : t_cs
   task automatic t_live;
      H.cycle(1'b0, 1'b0, 1'b1, 1'b0, 8'h22, 8'h5C, q, ok);
      `CHK("live_ack", 1'b1, ok)
      `CHK("live_upd", 8'h22, H.upd.addr)
      H.cycle(1'b0, 1'b1, 1'b1, 1'b0, 8'h22, 8'h00, q, ok);
      `CHK("live_rd", 8'h5C, q)
      @(posedge mclk);
      mode <= 2'h2;
      H.cycle(1'b0, 1'b1, 1'b1, 1'b1, 8'h22, 8'h00, q, ok);
      `CHK("mode2_ack", 1'b0, ok)
      @(posedge mclk);
      mode <= 2'h3;
      H.cycle(1'b0, 1'b0, 1'b1, 1'b1, 8'h22, 8'h77, q, ok);
      `CHK("mode3_ack", 1'b0, ok)
      @(posedge mclk);
      mode <= 2'h0;
      H.cycle(1'b0, 1'b1, 1'b1, 1'b1, 8'h22, 8'h00, q, ok);
      `CHK("mode3_kept", 8'h5C, q)
   endtask : t_live
   task automatic t_freeze;
      @(posedge mclk);
      ce <= 1'b0;
      H.cycle(1'b0, 1'b0, 1'b1, 1'b1, 8'h44, 8'h9D, q, ok);
      `CHK("frozen_ack", 1'b0, ok)
      @(posedge mclk);
      ce <= 1'b1;
      H.cycle(1'b0, 1'b1, 1'b1, 1'b1, 8'h44, 8'h00, q, ok);
      `CHK("frozen_kept", 8'h00, q)
   endtask : t_freeze
   //----------------------------------------
   // Verdict
   //----------------------------------------
   task automatic stop_test;
      $display("checks_done %0d n_fail %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test
   initial begin
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (3) @(posedge mclk);
      t_map();
      t_id();
      t_dir();
      t_cs();
      t_live();
      t_freeze();
      stop_test();
   end
endmodule : tb_top
